/* File: plc_irq_regs.svh */
/*
 * Constants of the event interrupt dispatcher: event range, routine range,
 * field widths and reset values.
 * Assumes: included by bare name from the package and the design modules.
 */
`ifndef PLC_IRQ_REGS_SVH
`define PLC_IRQ_REGS_SVH

// event numbers 0 to 26
`define IRQ_EVT_COUNT 27
`define IRQ_EVT_MAX 5'h1a
`define IRQ_EVT_W 5

// routine numbers 0 to 127
`define IRQ_ROUTINE_W 7

// reset values and queue depth
`define IRQ_GLOBAL_EN_RST 1'b0
`define IRQ_ROUTINE_RST 7'h00
`define IRQ_QUEUE_DEPTH 32

`endif

/* File: plc_irq_pkg.sv */
/*
 * Types shared by the dispatcher and its event queue: operation codes and
 * dispatcher states.
 * Assumes: plc_irq_regs.svh is on the include path.
 */
`include "plc_irq_regs.svh"

package plc_irq_pkg;

	// operation presented by the instruction sequencer
	typedef enum logic [2:0]
	{
		op_none,
		link_event_op,
		unlink_event_op,
		global_irq_enable_op,
		global_irq_disable_op,
		conditional_return,
		unconditional_return
	} irq_op_t;

	// dispatcher state
	typedef enum logic
	{
		st_main,
		st_routine
	} disp_state_t;

	typedef logic [`IRQ_EVT_W-1:0] evt_num_t;
	typedef logic [`IRQ_ROUTINE_W-1:0] routine_num_t;

endpackage

/* File: evq_if.sv */
/*
 * Carrier between the dispatcher and its ordered event queue.
 * Assumes: one clock domain; the queue answers combinationally.
 */
`timescale 1ns/100ps
`default_nettype none

interface evq_if;
	import plc_irq_pkg::*;

	logic push; // write one event number
	evt_num_t push_event; // event to write
	logic pop; // drop head entry
	evt_num_t head_event; // oldest entry
	logic empty; // nothing queued
	logic full; // no room

	modport producer
	(
		output push,
		output push_event,
		output pop,
		input head_event,
		input empty,
		input full
	);

	modport store
	(
		input push,
		input push_event,
		input pop,
		output head_event,
		output empty,
		output full
	);
endinterface

`default_nettype wire

/* File: plc_event_queue.sv */
/*
 * First-in first-out store of event numbers awaiting dispatch.
 * Assumes: producer never pushes when full nor pops when empty.
 */
`timescale 1ns/100ps
`default_nettype none

`include "plc_irq_regs.svh"

module plc_event_queue
#(
	parameter int DEPTH = `IRQ_QUEUE_DEPTH
)
(
	input wire logic clk,
	input wire logic reset,
	evq_if.store q
);
	import plc_irq_pkg::*;

	localparam int AW = $clog2(DEPTH);

	evt_num_t mem_r [DEPTH]; // queued event numbers
	logic [AW-1:0] wr_ptr_r; // next free slot
	logic [AW-1:0] rd_ptr_r; // oldest slot
	logic [AW:0] count_r; // entries held

	// storage array, no reset needed
	always_ff @(posedge clk)
	begin
		if (q.push)
			mem_r[wr_ptr_r] <= q.push_event;
	end

	// pointers wrap; depth is a power of two by default
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (q.push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			if (q.pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			if (q.push && !q.pop)
				count_r <= count_r + 1'b1;
			else if (q.pop && !q.push)
				count_r <= count_r - 1'b1;
		end
	end

	assign q.head_event = mem_r[rd_ptr_r];
	assign q.empty = (count_r == '0);
	assign q.full = (count_r == (AW+1)'(DEPTH));
endmodule

`default_nettype wire

/* File: plc_event_interrupt_dispatch.sv */
/*
 * Event interrupt dispatcher of the controller CPU: event-to-routine table,
 * per-event and global enables, ordered queue of occurrences, dispatch at
 * instruction boundaries, context save and restore, conditional and
 * unconditional return.
 * Assumes: operations, run entry and event pulses come from logic on clk;
 * insn_boundary marks the gap between two instructions; the sequencer jumps
 * to dispatch_routine_r when dispatch_r pulses and loads ctx_restore_data_r
 * when ctx_restore_r pulses.
 */
`timescale 1ns/100ps
`default_nettype none

`include "plc_irq_regs.svh"

// Summary of operation
// - link stores routine for event, sets enable
// - unlink clears event enable; later occurrences ignored
// - global enable allows dispatch of linked events
// - globally disabled: queue occurrences, start no routine
// - entering run clears the global enable
// - routine numbers 0 to 127 are entry points
// - save context on entry, restore on return
// - conditional return only when logic result true
// - dispatch only between instructions, never inside
// - relink replaces link; latest routine runs
module plc_event_interrupt_dispatch
#(
	parameter int CTX_W = 64,
	parameter int QUEUE_DEPTH = `IRQ_QUEUE_DEPTH
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic op_valid,
	input wire plc_irq_pkg::irq_op_t op_code,
	input wire plc_irq_pkg::evt_num_t op_event,
	input wire plc_irq_pkg::routine_num_t op_routine,
	input wire logic logic_result,
	input wire logic insn_boundary,
	input wire logic run_entry,
	input wire logic [`IRQ_EVT_COUNT-1:0] event_pulse,
	input wire logic [CTX_W-1:0] ctx_live,
	output logic dispatch_r,
	output plc_irq_pkg::routine_num_t dispatch_routine_r,
	output logic in_routine_r,
	output logic return_r,
	output logic ctx_restore_r,
	output logic [CTX_W-1:0] ctx_restore_data_r,
	output logic global_en_r,
	output logic [`IRQ_EVT_COUNT-1:0] event_en_r
);
	import plc_irq_pkg::*;

	localparam int N = `IRQ_EVT_COUNT;

	routine_num_t routine_tab_r [N]; // routine linked to each event
	logic [N-1:0] pending_r; // occurrences not yet in the queue
	logic [N-1:0] push_sel; // one-hot: pending bit moving to queue
	logic push_any; // a pending bit moves this cycle
	evt_num_t push_idx; // its event number
	disp_state_t state_r; // main program or inside a routine
	logic [CTX_W-1:0] ctx_save_r; // context of interrupted program
	logic op_link; // decoded link operation, in range
	logic op_unlink; // decoded unlink operation, in range
	logic do_pop; // head leaves the queue
	logic do_dispatch; // head starts its routine
	logic do_return; // routine hands back control

	evq_if evq ();

	plc_event_queue #(.DEPTH(QUEUE_DEPTH)) u_queue
	(
		.clk(clk),
		.reset(reset),
		.q(evq.store)
	);

	// operations with an event outside 0..26 are ignored
	assign op_link = op_valid && (op_code == link_event_op) && (op_event <= `IRQ_EVT_MAX);
	assign op_unlink = op_valid && (op_code == unlink_event_op) && (op_event <= `IRQ_EVT_MAX);

	// per-event table entry, enable and pending latch
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_evt
			// relink simply overwrites, so only the newest routine is kept
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					routine_tab_r[gi] <= `IRQ_ROUTINE_RST;
				else if (op_link && op_event == evt_num_t'(gi))
					routine_tab_r[gi] <= op_routine;
			end

			// link sets, unlink clears the individual enable
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					event_en_r[gi] <= 1'b0;
				else if (op_link && op_event == evt_num_t'(gi))
					event_en_r[gi] <= 1'b1;
				else if (op_unlink && op_event == evt_num_t'(gi))
					event_en_r[gi] <= 1'b0;
			end

			// recorded whatever the global enable; a new occurrence wins
			// over the move to the queue, so none is lost in that cycle
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					pending_r[gi] <= 1'b0;
				else if (event_pulse[gi] && event_en_r[gi])
					pending_r[gi] <= 1'b1;
				else if (push_sel[gi])
					pending_r[gi] <= 1'b0;
			end
		end
	endgenerate

	// lowest pending event enters the queue, one per cycle;
	// a full queue holds it back, so repeats of it merge meanwhile
	always_comb
	begin
		push_sel = '0;
		push_any = 1'b0;
		push_idx = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (pending_r[i] && !evq.full)
			begin
				push_any = 1'b1;
				push_idx = evt_num_t'(i);
			end
		end
		if (push_any)
			push_sel[push_idx] = 1'b1;
	end

	assign evq.push = push_any;
	assign evq.push_event = push_idx;

	// head leaves only between instructions, with the global enable set
	// and no routine running; an unlinked head is dropped, not run
	assign do_pop = (state_r == st_main) && global_en_r && !evq.empty && insn_boundary;
	assign do_dispatch = do_pop && event_en_r[evq.head_event];
	assign evq.pop = do_pop;

	// either return form ends the routine; conditional needs a true result
	always_comb
	begin
		do_return = 1'b0;
		if (state_r == st_routine && op_valid)
		begin
			case (op_code)
				unconditional_return: do_return = 1'b1;
				conditional_return: do_return = logic_result;
				default: do_return = 1'b0;
			endcase
		end
	end

	// dispatcher state
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			state_r <= st_main;
		else
		begin
			case (state_r)
				st_main:
					if (do_dispatch)
						state_r <= st_routine;
				st_routine:
					if (do_return)
						state_r <= st_main;
				default:
					state_r <= st_main;
			endcase
		end
	end

	// run entry beats an enable in the same cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			global_en_r <= `IRQ_GLOBAL_EN_RST;
		else if (run_entry)
			global_en_r <= 1'b0;
		else if (op_valid && op_code == global_irq_disable_op)
			global_en_r <= 1'b0;
		else if (op_valid && op_code == global_irq_enable_op)
			global_en_r <= 1'b1;
	end

	// context capture at entry and give-back at return
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctx_save_r <= '0;
			ctx_restore_data_r <= '0;
			ctx_restore_r <= 1'b0;
		end
		else
		begin
			ctx_restore_r <= do_return;
			if (do_dispatch)
				ctx_save_r <= ctx_live;
			if (do_return)
				ctx_restore_data_r <= ctx_save_r;
		end
	end

	// dispatch and return strobes towards the sequencer
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			dispatch_r <= 1'b0;
			dispatch_routine_r <= `IRQ_ROUTINE_RST;
			return_r <= 1'b0;
			in_routine_r <= 1'b0;
		end
		else
		begin
			dispatch_r <= do_dispatch;
			return_r <= do_return;
			if (do_dispatch)
				dispatch_routine_r <= routine_tab_r[evq.head_event];
			if (do_dispatch)
				in_routine_r <= 1'b1;
			else if (do_return)
				in_routine_r <= 1'b0;
		end
	end
endmodule

`default_nettype wire

/* File: plc_irq_checker_sva.sv */
/*
 * checker of the event interrupt dispatcher, bound to its top module.
 * assumes one clock, reset async active high.
 */
`timescale 1ns/100ps
`default_nettype none

module plc_irq_checker
(
	input wire logic clk,
	input wire logic reset,
	input wire logic op_valid,
	input wire plc_irq_pkg::irq_op_t op_code,
	input wire plc_irq_pkg::evt_num_t op_event,
	input wire logic logic_result,
	input wire logic insn_boundary,
	input wire logic run_entry,
	input wire logic dispatch_r,
	input wire logic in_routine_r,
	input wire logic return_r,
	input wire logic ctx_restore_r,
	input wire logic global_en_r,
	input wire logic [26:0] event_en_r
);
	import plc_irq_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_link_sets_en: assert property (
		op_valid && op_code == link_event_op && op_event <= 5'h1a |=> event_en_r[$past(op_event)])
		else $error("link left enable clear");
	a_unlink_clears: assert property (
		op_valid && op_code == unlink_event_op && op_event <= 5'h1a |=> !event_en_r[$past(op_event)])
		else $error("unlink left enable set");
	a_enable_sets: assert property (
		op_valid && op_code == global_irq_enable_op && !run_entry |=> global_en_r)
		else $error("global enable not set");
	a_gate_global: assert property (dispatch_r |-> $past(global_en_r)) else $error("dispatch while disabled");
	a_run_clears: assert property (run_entry |=> !global_en_r) else $error("run entry kept enable");
	a_gap_only: assert property (dispatch_r |-> $past(insn_boundary)) else $error("dispatch inside instruction");
	a_one_at_time: assert property (dispatch_r |-> in_routine_r ##1 !dispatch_r) else $error("dispatch not single");
	a_return_pair: assert property (
		return_r |-> ctx_restore_r && !in_routine_r && $past(in_routine_r))
		else $error("return without restore");
	a_cond_false: assert property (
		op_valid && op_code == conditional_return && !logic_result |=> !return_r)
		else $error("return on false result");
	a_return_cause: assert property (
		return_r |-> $past(op_valid) && ($past(op_code) == unconditional_return
		|| $past(op_code) == conditional_return && $past(logic_result)))
		else $error("return uncaused");
	c_dispatch: cover property (dispatch_r);
	c_return: cover property (return_r);
	c_run: cover property (run_entry);
endmodule

bind plc_event_interrupt_dispatch plc_irq_checker u_plc_irq_checker (.clk, .reset, .op_valid, .op_code,
	.op_event, .logic_result, .insn_boundary, .run_entry, .dispatch_r, .in_routine_r, .return_r,
	.ctx_restore_r, .global_en_r, .event_en_r);

`default_nettype wire

/* File: seq_model.sv */
/*
 * sequencer stand-in: instruction gaps and a live context.
 * assumes the dispatcher's clock and reset.
 */
`timescale 1ns/100ps
`default_nettype none

module seq_model
(
	input wire logic clk,
	input wire logic reset,
	output logic insn_boundary,
	output logic [63:0] ctx_live
);
	logic [1:0] phase_r; // instruction phase
	// gap in two cycles of three, so dispatch must wait out an instruction
	always_ff @(posedge clk or posedge reset)
		if (reset)
			phase_r <= 2'h0;
		else
			phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
	assign insn_boundary = phase_r != 2'h0;
	// context moves every cycle, so a late save shows
	always_ff @(posedge clk or posedge reset)
		if (reset)
			ctx_live <= 64'h0;
		else
			ctx_live <= ctx_live + 64'h1111;
endmodule

`default_nettype wire

/* File: tb_top.sv */
/*
 * self-checking bench of the event interrupt dispatcher.
 * assumes seq_model gives instruction gaps and context.
 */
`timescale 1ns/100ps
`default_nettype none
`define chk(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("mismatch %s exp %0h got %0h", n, e, a); end end

module tb_top;
	import plc_irq_pkg::*;
	logic clk = 0, reset = 1, op_valid = 0, logic_result = 0, run_entry = 0;
	irq_op_t op_code = op_none;
	evt_num_t op_event = '0;
	routine_num_t op_routine = '0, dispatch_routine_r;
	logic [26:0] event_pulse = '0, event_en_r;
	logic insn_boundary, dispatch_r, in_routine_r, return_r, ctx_restore_r, global_en_r;
	logic [63:0] ctx_live, ctx_restore_data_r, ctx_prev, ctx_saved;
	int fails = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	// context as sampled at the last edge
	always @(posedge clk) ctx_prev <= ctx_live;
	seq_model u_seq_model (.clk, .reset, .insn_boundary, .ctx_live);
	plc_event_interrupt_dispatch #(.QUEUE_DEPTH(4)) u_plc_event_interrupt_dispatch (.clk, .reset, .op_valid,
		.op_code, .op_event, .op_routine, .logic_result, .insn_boundary, .run_entry, .event_pulse, .ctx_live,
		.dispatch_r, .dispatch_routine_r, .in_routine_r, .return_r, .ctx_restore_r, .ctx_restore_data_r,
		.global_en_r, .event_en_r);
	task give_verdict;
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task op(input irq_op_t c, input evt_num_t e, input routine_num_t r, input logic lr);
		@(posedge clk);
		op_valid <= 1;
		op_code <= c;
		op_event <= e;
		op_routine <= r;
		logic_result <= lr;
		@(posedge clk);
		op_valid <= 0;
		#1;
	endtask
	task pulse(input evt_num_t e);
		@(posedge clk);
		event_pulse <= 27'h1 << e;
		@(posedge clk);
		event_pulse <= '0;
	endtask
	task idle_check;
		repeat (12) @(posedge clk);
		#1;
	endtask
	task wait_disp(input routine_num_t r);
		for (int i = 0; i < 30 && dispatch_r !== 1'b1; i++)
			@(posedge clk) #1;
		`chk("dispatch", 1'b1, dispatch_r)
		`chk("routine", r, dispatch_routine_r)
		ctx_saved = ctx_prev;
	endtask
	task ret(input irq_op_t c, input logic lr, input logic x);
		op(c, 5'h0, 7'h0, lr);
		`chk("return", x, return_r)
		`chk("restore strobe", x, ctx_restore_r)
		if (x)
			`chk("restore", ctx_saved, ctx_restore_data_r)
	endtask
	task t_link;
		`chk("reset enables", 28'h0, {global_en_r, event_en_r})
		op(link_event_op, 5'd3, 7'd9, 0);
		op(link_event_op, 5'd26, 7'd127, 0);
		op(link_event_op, 5'd27, 7'd1, 0);
		op(link_event_op, 5'd7, 7'd20, 0);
		op(link_event_op, 5'd3, 7'd5, 0);
		`chk("linked", 27'h4000088, event_en_r)
		op(unlink_event_op, 5'd7, 7'h0, 0);
		`chk("unlinked", 27'h4000008, event_en_r)
	endtask
	// arrival order 26 then 3 differs from index order
	task t_queue;
		pulse(5'd26);
		pulse(5'd3);
		pulse(5'd7);
		idle_check;
		`chk("held", 1'b0, in_routine_r)
		op(global_irq_enable_op, 5'h0, 7'h0, 0);
		// routines here hold nothing but their returns, no barred operation
		wait_disp(7'd127);
		ret(conditional_return, 0, 0);
		ret(conditional_return, 1, 1);
		wait_disp(7'd5);
		ret(unconditional_return, 0, 1);
		idle_check;
		`chk("dropped", 1'b0, in_routine_r)
	endtask
	task t_run;
		op(global_irq_disable_op, 5'h0, 7'h0, 0);
		`chk("disabled", 1'b0, global_en_r)
		op(global_irq_enable_op, 5'h0, 7'h0, 0);
		@(posedge clk);
		run_entry <= 1;
		@(posedge clk);
		run_entry <= 0;
		#1;
		`chk("run clears", 1'b0, global_en_r)
		pulse(5'd3);
		idle_check;
		`chk("no start", 1'b0, in_routine_r)
		// queued event 3 loses its link before the enable, so the head is dropped
		op(unlink_event_op, 5'd3, 7'h0, 0);
		op(global_irq_enable_op, 5'h0, 7'h0, 0);
		idle_check;
		`chk("head dropped", 1'b0, in_routine_r)
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 0;
		#1;
		t_link;
		t_queue;
		t_run;
		give_verdict;
	end
	// hang guard, well past the under two hundred cycles the tests need
	initial
	begin
		repeat (3000) @(posedge clk);
		fails++;
		give_verdict;
	end
endmodule

`default_nettype wire
